// ===== core/rps_ctrl.sv
// receive pool select registers and round-robin transfer scheduler
// assumes a classic wishbone master, a queue manager asking for pools,
// and a dma credit sink with a ready handshake, all on clk_i
//
// Operation
// [R1] first buffer uses first pool and manager
// [R2] second buffer uses second pool and manager
// [R3] third buffer uses third pool and manager
// [R4] fourth and later buffers use later pool
// [R5] four channels, each with independent pool settings
// [R6] last entry N gives N+1 active entries
// [R7] table of 64 words holds the entries
// [R8] disabled scheduler fetches nothing, passes no credit; a credit loaded before ena clears stays valid one more cycle
// [R9] software enables only after filling the table
// [R10] entry holds direction bit and channel number
// [R11] each fetched entry yields one credit
// [R12] entries step from zero to last, then wrap
// [R13] reserved bits read zero, writes ignored
`timescale 1ns/100ps
`default_nettype none
`include "rps_map.svh"

module rps_ctrl
	import rps_pkg::*;
(
	// clock and reset
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	// wishbone slave
	input  wire logic                       wb_cyc_i,
	input  wire logic                       wb_stb_i,
	input  wire logic                       wb_we_i,
	input  wire logic [`RPS_ADR_W-1:0]      wb_adr_i,
	input  wire logic [3:0]                 wb_sel_i,
	input  wire logic [31:0]                wb_dat_i,
	output logic      [31:0]                wb_dat_o,
	output logic                            wb_ack_o,
	// pool lookup from the queue manager side
	input  wire logic                       alloc_req_i,
	input  wire logic [1:0]                 alloc_chan_i,
	input  wire logic [7:0]                 alloc_buf_idx_i,
	output logic                            alloc_vld_o,
	output logic      [`RPS_QNUM_W-1:0]     alloc_queue_o,
	output logic      [`RPS_QMGR_W-1:0]     alloc_mgr_o,
	// credits to the dma channel logic
	input  wire logic                       credit_rdy_i,
	output logic                            credit_vld_o,
	output logic                            credit_rx_o,
	output logic      [`RPS_ENT_CHAN_W-1:0] credit_chan_o
);

	rps_state_t s_q;                             // registered state
	rps_state_t s_d;                             // next state

	// bus decode
	logic                    bus_req;           // request present, not yet acked
	logic                    wr_en;             // write takes effect this edge
	logic [`RPS_ADR_W-1:0]   pofs;              // offset inside pool block
	logic                    pool_hit;          // address in pool block
	logic [1:0]              pool_ch;           // channel of pool access
	logic [1:0]              pool_slot;         // buffer slot of pool access
	logic                    tbl_hit;           // address in table
	logic [5:0]              tbl_word;          // table word index
	logic [31:0]             lane_m;            // byte lane mask
	logic [31:0]             rdata;             // read mux output
	// scheduler fetch
	logic [31:0]             cur_word;          // table word at idx
	logic [15:0]             cur_half;          // half word at idx
	logic [`RPS_ENT_W-1:0]   cur_ent;           // entry at idx
	logic                    fetch;             // load an entry this cycle
	// pool lookup
	logic [1:0]              slot_sel;          // slot from buffer number

	// byte lane mask from wishbone selects
	function automatic logic [31:0] rps_lane_mask(input logic [3:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			m[b*8 +: 8] = {8{sel[b]}};
		end
		return m;
	endfunction

	// merge write data into old value on enabled lanes, drop reserved bits
	function automatic logic [31:0] rps_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [31:0] m, input logic [31:0] fmask);
		rps_merge = ((old & ~m) | (wd & m)) & fmask;
	endfunction

	// address decode
	always_comb begin
		bus_req   = wb_cyc_i && wb_stb_i && !s_q.ack;
		wr_en     = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;
		pofs      = wb_adr_i - `RPS_OFF_POOL_BASE;
		pool_hit  = (wb_adr_i >= `RPS_OFF_POOL_BASE) && (pofs < `RPS_POOL_SPAN);
		pool_ch   = pofs[5:4];
		pool_slot = pofs[3:2];
		tbl_hit   = wb_adr_i >= `RPS_OFF_TBL_BASE;
		tbl_word  = wb_adr_i[7:2];
		lane_m    = rps_lane_mask(wb_sel_i);
	end

	// read mux, reserved bits and unmapped words read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (pool_hit) begin
			rdata = {18'h0_0000, s_q.pool[pool_ch][pool_slot]}; // R5 R13
		end else if (tbl_hit) begin
			rdata = s_q.tbl[tbl_word] & `RPS_TBL_MASK; // R13
		end else if (wb_adr_i == `RPS_OFF_LAST) begin
			rdata = {24'h00_0000, s_q.last}; // R13
		end else if (wb_adr_i == `RPS_OFF_ENA) begin
			rdata = {16'h0000, s_q.ena, 15'h0000}; // R13
		end
	end

	// entry at the scheduler index: word, half, then byte
	always_comb begin
		cur_word = s_q.tbl[s_q.idx[7:2]]; // R7
		cur_half = s_q.idx[1] ? cur_word[31:16] : cur_word[15:0];
		cur_ent  = s_q.idx[0] ? cur_half[15:8] : cur_half[7:0]; // R10
		// fetch only while running and enabled, so a disable stops it at once
		fetch    = (s_q.st == RPS_RUN) && s_q.ena && (!s_q.cr_vld || credit_rdy_i); // R8
	end

	// buffer number to pool slot, fourth and later share the last slot
	always_comb begin
		slot_sel = (alloc_buf_idx_i > 8'h03) ? 2'h3 : alloc_buf_idx_i[1:0]; // R1 R2 R3 R4
	end

	// next state
	always_comb begin
		s_d = s_q;
		// wishbone ack one cycle after the request, dropped after one cycle
		s_d.ack = bus_req;
		// read data taken at the request edge, so it stands together with ack
		if (bus_req && !wb_we_i) begin
			s_d.dat = rdata;
		end
		// register writes at the edge where ack is seen
		if (wr_en) begin
			if (pool_hit) begin
				s_d.pool[pool_ch][pool_slot] = 14'(rps_merge({18'h0_0000,
					s_q.pool[pool_ch][pool_slot]}, wb_dat_i, lane_m,
					`RPS_POOL_MASK)); // R5 R13
			end else if (tbl_hit) begin
				s_d.tbl[tbl_word] = rps_merge(s_q.tbl[tbl_word], wb_dat_i, lane_m,
					`RPS_TBL_MASK); // R7 R13
			end else if (wb_adr_i == `RPS_OFF_LAST) begin
				s_d.last = 8'(rps_merge({24'h00_0000, s_q.last}, wb_dat_i, lane_m,
					`RPS_LAST_MASK)); // R6
			end else if (wb_adr_i == `RPS_OFF_ENA && wb_sel_i[1]) begin
				s_d.ena = wb_dat_i[`RPS_ENA_BIT];
			end
		end
		// pool lookup answered one cycle after the request
		s_d.al_vld = alloc_req_i;
		if (alloc_req_i) begin
			s_d.al = s_q.pool[alloc_chan_i][slot_sel]; // R1 R2 R3 R4
		end
		// scheduler
		unique case (s_q.st)
			RPS_IDLE: begin
				s_d.cr_vld = 1'b0; // R8
				s_d.idx    = 8'h00;
				if (s_q.ena) begin
					s_d.st = RPS_RUN;
				end
			end
			RPS_RUN: begin
				if (!s_q.ena) begin
					// disable drops any pending credit and restarts at zero
					s_d.st     = RPS_IDLE;
					s_d.cr_vld = 1'b0; // R8
					s_d.idx    = 8'h00;
				end else if (fetch) begin
					// credit slot free or taken this edge, load the next entry
					s_d.cr_vld  = 1'b1; // R11
					s_d.cr_rx   = cur_ent[`RPS_ENT_DIR_BIT]; // R10 R11
					s_d.cr_chan = cur_ent[`RPS_ENT_CHAN_LSB +: `RPS_ENT_CHAN_W];
					// wrap after the last entry, also if last was lowered
					s_d.idx = (s_q.idx >= s_q.last) ? 8'h00 : s_q.idx + 8'h01; // R6 R12
				end
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// whole state cleared, scheduler parked in idle at entry zero
			s_q    <= '0;
			s_q.st <= RPS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o      = s_q.dat;
	assign wb_ack_o      = s_q.ack;
	assign alloc_vld_o   = s_q.al_vld;
	assign alloc_queue_o = s_q.al.queue;
	assign alloc_mgr_o   = s_q.al.mgr;
	assign credit_vld_o  = s_q.cr_vld;
	assign credit_rx_o   = s_q.cr_rx;
	assign credit_chan_o = s_q.cr_chan;

	// helper views for the checks below
	rps_pool_t ref_first;                        // first slot of asked channel
	rps_pool_t ref_second;                       // second slot of asked channel
	rps_pool_t ref_third;                        // third slot of asked channel
	rps_pool_t ref_later;                        // later slot of asked channel
	rps_pool_t al_out;                           // lookup answer as a pool
	assign ref_first  = s_q.pool[alloc_chan_i][0];
	assign ref_second = s_q.pool[alloc_chan_i][1];
	assign ref_third  = s_q.pool[alloc_chan_i][2];
	assign ref_later  = s_q.pool[alloc_chan_i][3];
	assign al_out     = {alloc_mgr_o, alloc_queue_o};

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// read request, then its answer
	sequence rd_req_s;
		wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	endsequence
	sequence ena_rd_s;
		rd_req_s ##0 (wb_adr_i == `RPS_OFF_ENA);
	endsequence
	sequence last_rd_s;
		rd_req_s ##0 (wb_adr_i == `RPS_OFF_LAST);
	endsequence
	sequence tbl_rd_s;
		rd_req_s ##0 (wb_adr_i >= `RPS_OFF_TBL_BASE);
	endsequence
	sequence pool_rd_s;
		rd_req_s ##0 pool_hit;
	endsequence

	// pool lookup, channel pool, scheduler and control register readback checks

	AST_FIRST_POOL: assert property (alloc_req_i && alloc_buf_idx_i == 8'h00 // R1
		|=> alloc_vld_o && al_out == $past(ref_first))
		else $error("first buffer pool mismatch");
	AST_SECOND_POOL: assert property (alloc_req_i && alloc_buf_idx_i == 8'h01 // R2
		|=> alloc_vld_o && al_out == $past(ref_second))
		else $error("second buffer pool mismatch");
	AST_THIRD_POOL: assert property (alloc_req_i && alloc_buf_idx_i == 8'h02 // R3
		|=> alloc_vld_o && al_out == $past(ref_third))
		else $error("third buffer pool mismatch");
	AST_LATER_POOL: assert property (alloc_req_i && alloc_buf_idx_i >= 8'h03 // R4
		|=> alloc_vld_o && al_out == $past(ref_later))
		else $error("later buffer pool mismatch");
	AST_CHAN_INDEP: assert property (!(wr_en && pool_hit && pool_ch == 2'h1) // R5
		|=> $stable(s_q.pool[1]))
		else $error("channel one pools changed without a write to them");
	AST_WRAP: assert property (fetch && s_q.idx >= s_q.last // R6
		|=> s_q.idx == 8'h00)
		else $error("index did not wrap after last entry");
	AST_ENTRY_CREDIT: assert property (fetch // R7
		|=> credit_vld_o && credit_rx_o == $past(s_q.tbl[s_q.idx[7:2]][{s_q.idx[1:0], 3'h7}])
		&& credit_chan_o == $past(s_q.tbl[s_q.idx[7:2]][{s_q.idx[1:0], 3'h0} +: 4]))
		else $error("credit does not match table entry");
	AST_DISABLED_QUIET: assert property (!s_q.ena ##1 !s_q.ena // R8
		|-> !credit_vld_o && !fetch)
		else $error("credit while scheduler disabled");
	AST_CREDIT_HOLD: assert property (credit_vld_o && !credit_rdy_i && s_q.ena // R11
		|=> credit_vld_o && $stable(credit_chan_o) && $stable(credit_rx_o))
		else $error("pending credit lost or changed");
	AST_STEP: assert property (fetch && s_q.idx < s_q.last // R12
		|=> s_q.idx == $past(s_q.idx) + 8'h01)
		else $error("index did not step by one");
	AST_ENA_RSVD: assert property (ena_rd_s |=> wb_ack_o && wb_dat_o[14:0] == 15'h0000 // R13
		&& wb_dat_o[31:16] == 16'h0000)
		else $error("reserved scheduler enable bits not zero");
	AST_LAST_RSVD: assert property (last_rd_s |=> wb_ack_o // R13
		&& wb_dat_o[31:8] == 24'h00_0000 && wb_dat_o[7:0] == $past(s_q.last))
		else $error("last entry readback wrong");

	// table and pool reads, reserved bits zero
	AST_TBL_RSVD: assert property (tbl_rd_s |=> wb_ack_o // R13
		&& wb_dat_o == ($past(s_q.tbl[wb_adr_i[7:2]]) & `RPS_TBL_MASK))
		else $error("table readback wrong");
	AST_POOL_RSVD: assert property (pool_rd_s |=> wb_ack_o // R13
		&& wb_dat_o[31:14] == 18'h0_0000)
		else $error("reserved pool bits not zero");

	// register writes land at the ack edge
	AST_TBL_WRITE: assert property (wr_en && tbl_hit && wb_sel_i == 4'hf // R7
		|=> s_q.tbl[$past(wb_adr_i[7:2])] == ($past(wb_dat_i) & `RPS_TBL_MASK))
		else $error("table write lost");
	AST_LAST_WRITE: assert property (wr_en && wb_adr_i == `RPS_OFF_LAST && wb_sel_i[0] // R6
		|=> s_q.last == $past(wb_dat_i[7:0]))
		else $error("last entry write lost");
	AST_ENA_WRITE: assert property (wr_en && wb_adr_i == `RPS_OFF_ENA && wb_sel_i[1] // R8
		|=> s_q.ena == $past(wb_dat_i[15]))
		else $error("scheduler enable write lost");

	// scheduler quiet and parked at zero while disabled
	AST_IDLE_RESTART: assert property (!s_q.ena |=> s_q.idx == 8'h00) // R12
		else $error("index not back at zero while disabled");
	AST_CREDIT_NEEDS_ENA: assert property (credit_vld_o |-> $past(s_q.ena)) // R8
		else $error("credit raised while scheduler disabled");

	// lookup answers only requests
	AST_ALLOC_QUIET: assert property (!alloc_req_i |=> !alloc_vld_o) // R1
		else $error("lookup answer without request");

endmodule // rps_ctrl

`default_nettype wire

// ===== core/rps_map.svh
// constants of the receive pool select and transfer scheduler block
// assumes a 32-bit classic wishbone slave with byte addresses on wb_adr_i
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

// sizes
`define RPS_NUM_RX_CH      4
`define RPS_NUM_SLOTS      4
`define RPS_TBL_WORDS      64
`define RPS_ADR_W          9

// register byte offsets
`define RPS_OFF_LAST       9'h000
`define RPS_OFF_ENA        9'h004
`define RPS_OFF_POOL_BASE  9'h010
`define RPS_POOL_SPAN      9'h040
`define RPS_OFF_TBL_BASE   9'h100

// pool select fields
`define RPS_QNUM_LSB       0
`define RPS_QNUM_W         12
`define RPS_QMGR_LSB       12
`define RPS_QMGR_W         2
`define RPS_POOL_MASK      32'h0000_3fff

// scheduler control fields
`define RPS_LAST_W         8
`define RPS_LAST_MASK      32'h0000_00ff
`define RPS_ENA_BIT        15
`define RPS_ENA_MASK       32'h0000_8000

// table entry layout, four entries per 32-bit word
`define RPS_ENT_W          8
`define RPS_ENT_DIR_BIT    7
`define RPS_ENT_CHAN_LSB   0
`define RPS_ENT_CHAN_W     4
`define RPS_TBL_MASK       32'h8f8f_8f8f

// reset values
`define RPS_RST_POOL       14'h0000
`define RPS_RST_LAST       8'h00
`define RPS_RST_ENA        1'b0

`endif

// ===== core/rps_pkg.sv
// types of the receive pool select and transfer scheduler block
// assumes rps_map.svh on the include path
`default_nettype none
`include "rps_map.svh"

package rps_pkg;

	// one pool choice: manager and queue number
	typedef struct packed {
		logic [`RPS_QMGR_W-1:0] mgr;
		logic [`RPS_QNUM_W-1:0] queue;
	} rps_pool_t;

	// scheduler states, one-hot
	typedef enum logic [1:0] {
		RPS_IDLE = 2'b01,
		RPS_RUN  = 2'b10
	} rps_sched_st_t;

	// whole state of the block
	typedef struct packed {
		rps_pool_t [`RPS_NUM_RX_CH-1:0][`RPS_NUM_SLOTS-1:0] pool;
		logic [`RPS_LAST_W-1:0]                       last;
		logic                                         ena;
		logic [`RPS_TBL_WORDS-1:0][31:0]              tbl;
		rps_sched_st_t                                st;
		logic [`RPS_LAST_W-1:0]                       idx;
		logic                                         cr_vld;
		logic                                         cr_rx;
		logic [`RPS_ENT_CHAN_W-1:0]                   cr_chan;
		logic                                         al_vld;
		rps_pool_t                                    al;
		logic                                         ack;
		logic [31:0]                                  dat;
	} rps_state_t;

endpackage

`default_nettype wire

// ===== tb/rps_credit_sink.sv
// model of the dma channel credit logic that takes scheduler credits
// assumes the credit handshake runs on clk_i with synchronous reset
`timescale 1ns/100ps
`default_nettype none

module rps_credit_sink (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// stall control from the bench
	input  wire logic       slow_i,
	// credit handshake
	input  wire logic       vld_i,
	input  wire logic       rx_i,
	input  wire logic [3:0] chan_i,
	output logic            rdy_o
);
	logic [4:0] log_q [0:15]; // accepted credits, direction then channel
	logic [7:0] n_q;          // credits accepted so far
	logic       ph_q;         // stall phase

	// ready each cycle, or every other cycle while stalling
	assign rdy_o = ~slow_i | ph_q;

	// log every credit taken at a vld and rdy edge
	always_ff @(posedge clk_i) begin
		ph_q <= rst_i ? 1'b0 : ~ph_q;
		if (rst_i) begin
			n_q <= 8'h00;
		end else if (vld_i && rdy_o) begin
			log_q[n_q[3:0]] <= {rx_i, chan_i};
			n_q <= n_q + 8'h01;
		end
	end
endmodule // rps_credit_sink

`default_nettype wire

// ===== tb/tb_rps_ctrl.sv
// self-checking bench for the pool select and scheduler block
// assumes rps_pkg and rps_map.svh compiled first, sink model beside it
`timescale 1ns/100ps
`default_nettype none
`include "rps_map.svh"

module tb_rps_ctrl;
	logic        clk, rst, cyc, stb, we, ack, areq, avld, crdy, cvld, crx, slow;
	logic [8:0]  adr;   // byte address
	logic [3:0]  sel;   // byte enables
	logic [31:0] dw, dr, r;
	logic [1:0]  ach, am;
	logic [7:0]  abi, k;
	logic [11:0] aq;
	logic [3:0]  cch;
	logic [31:0] tw [0:1] = '{32'h738f_7281, 32'h0a85_f48e}; // table words
	int          n_errors, checks_done, cyc_cnt;

	rps_ctrl dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .alloc_req_i(areq), .alloc_chan_i(ach), .alloc_buf_idx_i(abi),
		.alloc_vld_o(avld), .alloc_queue_o(aq), .alloc_mgr_o(am), .credit_rdy_i(crdy),
		.credit_vld_o(cvld), .credit_rx_o(crx), .credit_chan_o(cch));
	rps_credit_sink sink (.clk_i(clk), .rst_i(rst), .slow_i(slow), .vld_i(cvld),
		.rx_i(crx), .chan_i(cch), .rdy_o(crdy));

	// clock, 4 ns period
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// hang guard
	always @(posedge clk) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			n_errors++;
			complete_run();
		end
	end

	// verdict and end of run
	task complete_run;
		if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// compare seen against expected
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask

	// one classic wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	// one pool lookup, answer one cycle later
	task automatic al(input int c, input int b, input logic [31:0] e);
		@(posedge clk);
		areq <= 1'b1;
		ach <= 2'(c);
		abi <= 8'(b);
		@(posedge clk);
		areq <= 1'b0;
		@(posedge clk);
		chk("alloc_vld", {31'h0, avld}, 32'h1);
		chk("alloc_pool", {18'h0, am, aq}, e & `RPS_POOL_MASK);
	endtask

	// pool register address and test pattern
	function automatic logic [8:0] pa(input int c, input int s);
		return `RPS_OFF_POOL_BASE + 9'(c * 16 + s * 4);
	endfunction
	function automatic logic [31:0] pat(input int c, input int s);
		return 32'hffff_c000 ^ 32'((c * 4 + s + 1) * 32'h0347);
	endfunction

	// main sequence
	initial begin
		{rst, cyc, stb, we, areq, slow} = 6'h21;
		{adr, dw, ach, abi, n_errors, checks_done} = '0;
		sel = 4'hf;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		wb(1'b0, `RPS_OFF_LAST, 32'h0, r);
		chk("last_rst", r, 32'h0);
		wb(1'b0, `RPS_OFF_ENA, 32'h0, r);
		chk("ena_rst", r, 32'h0);
		wb(1'b0, 9'h008, 32'h0, r);
		chk("unmapped", r, 32'h0);
		sel <= 4'hd;
		wb(1'b1, `RPS_OFF_ENA, 32'hffff_ffff, r);
		sel <= 4'hf;
		wb(1'b0, `RPS_OFF_ENA, 32'h0, r);
		chk("ena_sel", r, 32'h0);
		for (int c = 0; c < 4; c++) for (int s = 0; s < 4; s++) wb(1'b1, pa(c, s), pat(c, s), r);
		for (int c = 0; c < 4; c++) for (int s = 0; s < 4; s++) begin
			wb(1'b0, pa(c, s), 32'h0, r);
			chk("pool_reg", r, pat(c, s) & `RPS_POOL_MASK);
		end
		for (int c = 0; c < 4; c++) for (int b = 0; b < 5; b++) begin
			al(c, (b == 4) ? 255 : b, pat(c, (b > 3) ? 3 : b));
		end
		sel <= 4'h1;
		wb(1'b1, pa(0, 0), 32'h0, r);
		sel <= 4'hf;
		wb(1'b0, pa(0, 0), 32'h0, r);
		chk("pool_sel", r, pat(0, 0) & `RPS_POOL_MASK & 32'hffff_ff00);
		for (int w = 0; w < 2; w++) begin
			wb(1'b1, `RPS_OFF_TBL_BASE + 9'(w * 4), tw[w], r);
			wb(1'b0, `RPS_OFF_TBL_BASE + 9'(w * 4), 32'h0, r);
			chk("tbl_word", r, tw[w] & `RPS_TBL_MASK);
		end
		wb(1'b1, `RPS_OFF_LAST, 32'hffff_ff05, r);
		wb(1'b0, `RPS_OFF_LAST, 32'h0, r);
		chk("last_reg", r, 32'h5);
		chk("no_credit", {24'h0, sink.n_q}, 32'h0);
		wb(1'b1, `RPS_OFF_ENA, 32'hffff_ffff, r);
		wb(1'b0, `RPS_OFF_ENA, 32'h0, r);
		chk("ena_reg", r, `RPS_ENA_MASK);
		while (sink.n_q < 8'h08) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			r = (tw[(i % 6) / 4] & `RPS_TBL_MASK) >> (8 * ((i % 6) % 4));
			chk("credit", {27'h0, sink.log_q[i]}, {27'h0, r[7], r[3:0]});
		end
		wb(1'b1, `RPS_OFF_ENA, 32'h0, r);
		repeat (3) @(posedge clk);
		k = sink.n_q;
		repeat (20) @(posedge clk);
		chk("stopped", {24'h0, sink.n_q}, {24'h0, k});
		chk("credit_vld", {31'h0, cvld}, 32'h0);
		complete_run();
	end
endmodule // tb_rps_ctrl

`default_nettype wire
